// >>> src/cisel_defines.svh
// register offsets, field positions, reset values and counts of the interrupt source selector
// assumes a 32-bit APB slave with one register per aligned word
`ifndef CISEL_DEFINES_SVH
`define CISEL_DEFINES_SVH
`define CISEL_OFF_CTRL      8'h00
`define CISEL_OFF_BLKCFG    8'h04
`define CISEL_OFF_STATUS    8'h08
`define CISEL_OFF_CLEAR     8'h0C
`define CISEL_BIT_AIE       0
`define CISEL_BIT_ALT       1
`define CISEL_BIT_FIE       2
`define CISEL_BIT_DMA       3
`define CISEL_BIT_M1        4
`define CISEL_BIT_GATE      5
`define CISEL_BIT_MODE_N    6
`define CISEL_CTRL_W        7
`define CISEL_CTRL_RST      7'h00
`define CISEL_BLKCFG_RST    8'h01
`define CISEL_ST_PEND       0
`define CISEL_ST_FIFO       1
`define CISEL_ST_IRQ        2
`define CISEL_ST_DIN        3
`define CISEL_SAMPLES_BLK   9'h1FF
`define CISEL_FILT_LEN      4
`define CISEL_BLK_W         8
`endif

// >>> src/cisel_pkg.sv
// shared types of the interrupt source selector
// assumes the defines header is compiled alongside
package cisel_pkg;
  typedef logic [31:0] cisel_word_t;
  typedef logic [7:0]  cisel_addr_t;
endpackage

// >>> src/cisel_top.sv
// classic interrupt source selection with an APB register file
// assumes event inputs are one-cycle pulses synchronous to i_core_clk; i_digital_input_zero is asynchronous
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cisel_defines.svh"

// Behaviour
// - classic source mapping acts only while the FIFO-interrupt mode bit is zero.
// - enable clear, DMA set: terminal count sets pending flag, no interrupt.
// - enable set, DMA clear: each conversion interrupts when M1 clear or FIFO enable clear.
// - compatibility, bursting, M1 clear: interrupt for every sample of a burst.
// - compatibility, bursting, M1 set: interrupt once per completed burst.
// - enable and DMA set: terminal count interrupts, any M1.
// - all enables clear, M1 set: conversion sets pending flag, no interrupt.
// - M1 set, FIFO not the source: block flag set per queued block.
// - number of 512-sample blocks per flag or interrupt is programmable.
// - only FIFO enable set, M1 set: interrupt per filled block.
// - in FIFO-only setup, input-zero rising edge sets pending flag.
// - ADC and FIFO enables set, DMA clear, M1 set: interrupt per block.
// - in that setup, input-zero rising edge also interrupts.
// - host write to clear register deasserts the interrupt request.
// - clear write also resets pending flag set by input-zero edge.
// - with gate control set, input-zero rising edge marks sample group start.
module cisel_top #(
  parameter int FILT_LEN = `CISEL_FILT_LEN,
  parameter int BLK_W    = `CISEL_BLK_W
) (
  input  wire logic                i_core_clk,
  input  wire logic                i_rst_n,
  input  wire logic                i_psel,
  input  wire logic                i_penable,
  input  wire logic                i_pwrite,
  input  wire cisel_pkg::cisel_addr_t i_paddr,
  input  wire cisel_pkg::cisel_word_t i_pwdata,
  output logic                     o_pready,
  output logic                     o_pslverr,
  output cisel_pkg::cisel_word_t   o_prdata,
  input  wire logic                i_adc_done,
  input  wire logic                i_burst_done,
  input  wire logic                i_adc_bursting,
  input  wire logic                i_compat_jumper_select,
  input  wire logic                i_dma_tc,
  input  wire logic                i_fifo_push,
  input  wire logic                i_digital_input_zero,
  output logic                     o_irq,
  output logic                     o_int_flag,
  output logic                     o_fifo_block_flag,
  output logic                     o_gate_start
);
  import cisel_pkg::*;

  // refuse filter lengths and block widths that the shift filter and counters cannot serve
  if (FILT_LEN < 2 || FILT_LEN > 16 || BLK_W < 1 || BLK_W > 16) begin : g_bad_param
    $error("cisel_top: unsupported FILT_LEN or BLK_W");
  end

  logic [`CISEL_CTRL_W-1:0] ctrl, next_ctrl;
  logic [BLK_W-1:0]         blk_cfg, next_blk_cfg;
  logic                     irq, next_irq;
  logic                     pend, next_pend;
  logic                     fifo_flag, next_fifo_flag;
  logic                     din_seen, next_din_seen;
  cisel_word_t              rdata, next_rdata;
  logic                     sync1, sync2;
  logic [FILT_LEN-1:0]      filt, next_filt;
  logic                     din_level, next_din_level;
  logic [8:0]               smp_cnt, next_smp_cnt;
  logic [BLK_W-1:0]         blk_cnt, next_blk_cnt;

  logic apb_setup, apb_write, mapped, clr_wr;
  logic en_a, fifo_irq_enable, dma, m1, mode_n, gate;
  logic conv_evt, blk_evt, din_rise, fifo_src;
  logic irq_set, pend_set, fifo_set;

  // address decode used by the error answer; read capture decodes i_paddr with its own case
  function automatic logic is_mapped(input cisel_addr_t a);
    return (a == `CISEL_OFF_CTRL) || (a == `CISEL_OFF_BLKCFG) ||
           (a == `CISEL_OFF_STATUS) || (a == `CISEL_OFF_CLEAR);
  endfunction

  // bus phases; zero wait states so pready stays high
  assign apb_setup = i_psel && !i_penable;
  assign apb_write = i_psel && i_penable && i_pwrite;
  assign mapped    = is_mapped(i_paddr);
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && !mapped;
  assign o_prdata  = rdata;

  assign clr_wr = apb_write && (i_paddr == `CISEL_OFF_CLEAR);

  // control fields
  assign en_a   = ctrl[`CISEL_BIT_AIE] || ctrl[`CISEL_BIT_ALT];
  assign fifo_irq_enable    = ctrl[`CISEL_BIT_FIE];
  assign dma    = ctrl[`CISEL_BIT_DMA];
  assign m1     = ctrl[`CISEL_BIT_M1];
  assign gate   = ctrl[`CISEL_BIT_GATE];
  assign mode_n = ctrl[`CISEL_BIT_MODE_N];

  assign conv_evt = (i_compat_jumper_select && i_adc_bursting && m1) ? i_burst_done : i_adc_done;

  // input zero: two-flop synchroniser, then a shift filter
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= i_digital_input_zero;
      sync2 <= sync1;
    end
  end

  // stable-sample filter; a level change needs FILT_LEN equal samples, trading latency for glitch immunity
  always_comb begin
    next_filt      = {filt[FILT_LEN-2:0], sync2};
    next_din_level = din_level;
    if (&filt) begin
      next_din_level = 1'b1;
    end else if (~|filt) begin
      next_din_level = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      filt      <= '0;
      din_level <= 1'b0;
    end else begin
      filt      <= next_filt;
      din_level <= next_din_level;
    end
  end

  assign din_rise = next_din_level && !din_level;

  assign o_gate_start = din_rise && gate;

  // block counter: 512 pushes form a block, blk_cfg blocks form an event (zero acts as one)
  always_comb begin
    next_smp_cnt = smp_cnt;
    next_blk_cnt = blk_cnt;
    blk_evt      = 1'b0;
    if (i_fifo_push) begin
      next_smp_cnt = smp_cnt + 9'h001;
      if (smp_cnt == `CISEL_SAMPLES_BLK) begin
        next_smp_cnt = '0;
        if (blk_cnt + 1'b1 >= blk_cfg) begin
          next_blk_cnt = '0;
          blk_evt      = 1'b1;
        end else begin
          next_blk_cnt = blk_cnt + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      smp_cnt <= '0;
      blk_cnt <= '0;
    end else begin
      smp_cnt <= next_smp_cnt;
      blk_cnt <= next_blk_cnt;
    end
  end

  // source selection, only in classic mode
  assign fifo_src = fifo_irq_enable && !dma && m1;
  always_comb begin
    irq_set  = 1'b0;
    pend_set = 1'b0;
    fifo_set = 1'b0;
    if (!mode_n) begin
      if (dma) begin
        irq_set  = en_a && i_dma_tc;
        pend_set = i_dma_tc;
      end else if (en_a && (!m1 || !fifo_irq_enable)) begin
        irq_set  = conv_evt;
        pend_set = conv_evt;
      end else if (!en_a && !fifo_irq_enable && m1) begin
        pend_set = conv_evt;
      end else if (fifo_src) begin
        irq_set  = blk_evt || (en_a && din_rise);
        pend_set = din_rise || blk_evt;
      end
      fifo_set = m1 && !fifo_src && blk_evt;
    end
  end

  // register writes and flags; a set in the clear cycle wins
  always_comb begin
    next_ctrl      = ctrl;
    next_blk_cfg   = blk_cfg;
    next_irq       = irq_set || (irq && !clr_wr);
    next_pend      = pend_set || (pend && !clr_wr);
    next_fifo_flag = fifo_set || (fifo_flag && !clr_wr);
    next_din_seen  = din_rise || (din_seen && !clr_wr);
    next_rdata     = rdata;
    if (apb_write && i_paddr == `CISEL_OFF_CTRL) begin
      next_ctrl = i_pwdata[`CISEL_CTRL_W-1:0];
    end
    if (apb_write && i_paddr == `CISEL_OFF_BLKCFG) begin
      next_blk_cfg = i_pwdata[BLK_W-1:0];
    end
    // read data captured in setup so it comes from a flop in the access cycle
    if (apb_setup) begin
      next_rdata = '0;
      case (i_paddr)
        `CISEL_OFF_CTRL:   next_rdata[`CISEL_CTRL_W-1:0] = ctrl;
        `CISEL_OFF_BLKCFG: next_rdata[BLK_W-1:0] = blk_cfg;
        `CISEL_OFF_STATUS: begin
          next_rdata[`CISEL_ST_PEND] = pend;
          next_rdata[`CISEL_ST_FIFO] = fifo_flag;
          next_rdata[`CISEL_ST_IRQ]  = irq;
          next_rdata[`CISEL_ST_DIN]  = din_seen;
        end
        default:           next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl      <= `CISEL_CTRL_RST;
      blk_cfg   <= BLK_W'(`CISEL_BLKCFG_RST);
      irq       <= 1'b0;
      pend      <= 1'b0;
      fifo_flag <= 1'b0;
      din_seen  <= 1'b0;
      rdata     <= '0;
    end else begin
      ctrl      <= next_ctrl;
      blk_cfg   <= next_blk_cfg;
      irq       <= next_irq;
      pend      <= next_pend;
      fifo_flag <= next_fifo_flag;
      din_seen  <= next_din_seen;
      rdata     <= next_rdata;
    end
  end

  assign o_irq             = irq;
  assign o_int_flag        = pend;
  assign o_fifo_block_flag = fifo_flag;

  AST_MODE_QUIET: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    mode_n && !irq && !(apb_write && i_paddr == `CISEL_OFF_CTRL) |=> !irq)
    else $error("interrupt raised outside classic mode");
  AST_TC_POLL: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !mode_n && !en_a && dma && i_dma_tc && !irq |=> o_int_flag && !o_irq)
    else $error("polled terminal count wrong");
  AST_CONV_IRQ: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !mode_n && en_a && !dma && (!m1 || !fifo_irq_enable) && i_adc_done && !(i_compat_jumper_select && i_adc_bursting && m1)
    |=> o_irq)
    else $error("conversion did not interrupt");
  AST_BURST_ONCE: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !mode_n && en_a && !dma && !fifo_irq_enable && m1 && i_compat_jumper_select && i_adc_bursting && !i_burst_done
    && !irq && !clr_wr |=> !o_irq)
    else $error("burst mode interrupted per sample");
  AST_TC_IRQ: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !mode_n && en_a && dma && i_dma_tc |=> o_irq)
    else $error("terminal count did not interrupt");
  AST_CONV_POLL: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !mode_n && !en_a && !fifo_irq_enable && !dma && m1 && i_adc_done && !irq |=> o_int_flag && !o_irq)
    else $error("polled conversion wrong");
  AST_FIFO_IRQ: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !mode_n && fifo_src && blk_evt |=> o_irq)
    else $error("block fill did not interrupt");
  AST_DIN_IRQ: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !mode_n && fifo_src && en_a && din_rise |=> o_irq && o_int_flag)
    else $error("input edge did not interrupt");
  AST_CLEAR: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    clr_wr && !irq_set |=> !o_irq)
    else $error("clear write left request high");
  AST_FILTER: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    din_rise |-> $past(sync2, 1) && $past(sync2, 2))
    else $error("edge accepted without stable samples");
endmodule
`default_nettype wire

// >>> tb/cisel_push_model.sv
// fifo push source standing in for the acquisition front end
// assumes a run is started only while o_busy is low
`timescale 1ns/1ps
`default_nettype none
module cisel_push_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_start,
  input  wire logic [15:0] i_count,
  output logic             o_fifo_push,
  output logic             o_busy
);
  logic [15:0] left;
  logic        go;

  // pushes only every other cycle: a slow producer, never back to back
  assign go = (left != 16'h0000) && !o_fifo_push;
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      left <= 16'h0000;
      o_fifo_push <= 1'b0;
    end else if (i_start) begin
      left <= i_count;
      o_fifo_push <= 1'b0;
    end else begin
      o_fifo_push <= go;
      if (go) left <= left - 16'h0001;
    end
  end

  // busy until the last push has been sampled
  assign o_busy = (left != 16'h0000) || o_fifo_push;
endmodule
`default_nettype wire

// >>> tb/test_classic_irq_source_select.sv
// bench for the classic interrupt source selector: apb host, event pulses, push model
// assumes zero-wait apb and flags visible one cycle after the event edge
`timescale 1ns/1ps
`default_nettype none
`include "cisel_defines.svh"
module test_classic_irq_source_select;
  import cisel_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic        din, cb, bst, start, busy, push, irq, intf, blkf, gate;
  cisel_addr_t paddr;
  cisel_word_t pwdata, prdata, r;
  logic [2:0]  evs;
  logic [15:0] cnt;
  int          n_fail = 0, n_tests = 0, cyc = 0, gates = 0;
  // {ctrl, compat, events burst/tc/adc, bursting, expected irq/pending/block}
  logic [15:0] tab [14] = '{16'h0116, 16'h0216, 16'h0516, 16'h1116, 16'h0822, 16'h1822,
    16'h0926, 16'h1926, 16'h1012, 16'h4110, 16'h019E, 16'h1198, 16'h11CE, 16'h1196};

  cisel_top cisel_top_i (.i_core_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_prdata(prdata), .i_adc_done(evs[0]), .i_burst_done(evs[2]), .i_adc_bursting(bst),
    .i_compat_jumper_select(cb), .i_dma_tc(evs[1]), .i_fifo_push(push),
    .i_digital_input_zero(din), .o_irq(irq), .o_int_flag(intf), .o_fifo_block_flag(blkf),
    .o_gate_start(gate));
  cisel_push_model cisel_push_model_i (.i_core_clk(clk), .i_rst_n(rst_n), .i_start(start),
    .i_count(cnt), .o_fifo_push(push), .o_busy(busy));

  // free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // cycle ceiling, and a count of gate pulses since they last one cycle only
  always @(posedge clk) begin
    cyc++;
    if (gate === 1'b1) gates++;
    if (cyc == 10000) begin
      n_fail++;
      test_done;
    end
  end

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input cisel_word_t got, input cisel_word_t exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic fl(input logic [2:0] e);
    chk({29'h0, irq, intf, blkf}, {29'h0, e});
  endtask

  // one apb transfer; holds the request until pready is seen at an edge
  task automatic apb(input logic w, input cisel_addr_t a, input cisel_word_t d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic wr(input cisel_addr_t a, input cisel_word_t d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input cisel_addr_t a, input cisel_word_t e);
    apb(1'b0, a, 32'h0);
    chk(r, e);
  endtask

  task automatic ev(input logic [2:0] v);
    @(posedge clk);
    evs <= v;
    @(posedge clk);
    evs <= 3'h0;
    #1;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic pushn(input logic [15:0] n);
    @(posedge clk);
    start <= 1'b1;
    cnt <= n;
    @(posedge clk);
    start <= 1'b0;
    // look at busy only once the edge has settled, not in the step that launches it
    do begin
      @(posedge clk);
      #1;
    end while (busy === 1'b1);
  endtask

  task automatic t_regs;
    rd(`CISEL_OFF_CTRL, 32'h0);
    rd(`CISEL_OFF_BLKCFG, 32'h1);
    rd(`CISEL_OFF_STATUS, 32'h0);
    rd(8'h10, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(`CISEL_OFF_BLKCFG, 32'h3);
    rd(`CISEL_OFF_BLKCFG, 32'h3);
    rd(`CISEL_OFF_CLEAR, 32'h0);
  endtask

  task automatic t_map;
    foreach (tab[i]) begin
      wr(`CISEL_OFF_CTRL, {24'h0, tab[i][15:8]});
      @(posedge clk);
      cb <= tab[i][7];
      bst <= tab[i][3];
      ev(tab[i][6:4]);
      fl(tab[i][2:0]);
      wr(`CISEL_OFF_CLEAR, 32'h0);
      fl(3'h0);
    end
    @(posedge clk);
    cb <= 1'b0;
    bst <= 1'b0;
  endtask

  task automatic t_fifo;
    wr(`CISEL_OFF_CTRL, 32'h14);
    wr(`CISEL_OFF_BLKCFG, 32'h2);
    pushn(16'h3FF);
    fl(3'h0);
    pushn(16'h1);
    fl(3'h6);
    wr(`CISEL_OFF_CLEAR, 32'h0);
    wr(`CISEL_OFF_CTRL, 32'h10);
    wr(`CISEL_OFF_BLKCFG, 32'h1);
    pushn(16'h1FF);
    fl(3'h0);
    pushn(16'h1);
    fl(3'h1);
    wr(`CISEL_OFF_CLEAR, 32'h0);
    wr(`CISEL_OFF_CTRL, 32'h15);
    pushn(16'h200);
    fl(3'h6);
    wr(`CISEL_OFF_CLEAR, 32'h0);
  endtask

  task automatic t_din;
    wr(`CISEL_OFF_CTRL, 32'h34);
    @(posedge clk);
    din <= 1'b1;
    idle(12);
    fl(3'h2);
    chk(32'(gates), 32'h1);
    rd(`CISEL_OFF_STATUS, 32'h9);
    wr(`CISEL_OFF_CLEAR, 32'h0);
    rd(`CISEL_OFF_STATUS, 32'h0);
    @(posedge clk);
    din <= 1'b0;
    wr(`CISEL_OFF_CTRL, 32'h15);
    idle(10);
    // a two-sample glitch, shorter than the filter
    @(posedge clk);
    din <= 1'b1;
    idle(1);
    @(posedge clk);
    din <= 1'b0;
    idle(12);
    fl(3'h0);
    @(posedge clk);
    din <= 1'b1;
    idle(12);
    fl(3'h6);
    chk(32'(gates), 32'h1);
  endtask

  // reset, then the scenarios in turn
  initial begin
    {rst_n, psel, penable, pwrite, din, cb, bst, start, evs} = '0;
    {paddr, pwdata, cnt} = '0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_map;
    t_fifo;
    t_din;
    test_done;
  end
endmodule
`default_nettype wire
